// [core/cca_params.svh]
// Register offsets, field positions, reset values and counts of the counter array.
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH
`define CCA_ADDR_MODE5        8'hCE
`define CCA_ADDR_CMPL5        8'hD2
`define CCA_ADDR_CMPH5        8'hD3
`define CCA_ADDR_MODE0        8'hDA
`define CCA_ADDR_MODE1        8'hDB
`define CCA_ADDR_MODE2        8'hDC
`define CCA_ADDR_MODE3        8'hDD
`define CCA_ADDR_MODE4        8'hDE
`define CCA_ADDR_PWMCFG       8'hDF
`define CCA_ADDR_CMPL1        8'hE9
`define CCA_ADDR_CMPH1        8'hEA
`define CCA_ADDR_CMPL2        8'hEB
`define CCA_ADDR_CMPH2        8'hEC
`define CCA_ADDR_CMPL3        8'hED
`define CCA_ADDR_CMPH3        8'hEE
`define CCA_ADDR_CNTL         8'hF9
`define CCA_ADDR_CNTH         8'hFA
`define CCA_ADDR_CMPL0        8'hFB
`define CCA_ADDR_CMPH0        8'hFC
`define CCA_ADDR_CMPL4        8'hFD
`define CCA_ADDR_CMPH4        8'hFE
`define CCA_MODE_WIDE         7
`define CCA_MODE_CMP          6
`define CCA_MODE_RISE         5
`define CCA_MODE_FALL         4
`define CCA_MODE_MATCH        3
`define CCA_MODE_TOGGLE       2
`define CCA_MODE_PWM          1
`define CCA_MODE_IRQ          0
`define CCA_CFG_RELOAD_ACCESS_SELECT         7
`define CCA_CFG_COVIE         6
`define CCA_CFG_CYCLE_OVERFLOW_FLAG          5
`define CCA_CFG_WMASK         8'hE3
`define CCA_RESET_BYTE        8'h00
`define CCA_NUM_MODULES       6
`define CCA_WDOG_MODULE       5
`endif

// [core/cca_pkg.sv]
// Types shared by the counter array design.
package cca_pkg;
  typedef logic [7:0]  cca_byte_t;
  typedef logic [15:0] cca_word_t;
  typedef logic [1:0]  cca_cycle_length_select_t;
endpackage

// [core/cca_core.sv]
// Counter array with six capture/compare modules behind byte registers.
// Operation
// - Overflow of bit 8..11 sets cycle flag
// - Cycle flag set by hardware or software
// - Select codes give 8, 9, 10, 11 bits
// - Cycle length ignored by 16-bit PWM modules
// - Configuration bits 4..2 read zero
// - Mode bit 7 selects 16-bit PWM
// - Mode bit 6 enables comparator
// - Bits 5/4 enable rising/falling capture
// - Match sets module event flag
// - Toggle inverts pin on each match
// - Toggle plus PWM gives frequency output
// - PWM enable drives modulated waveform
// - Bit 0 masks module flag interrupt
// - Watchdog blocks module 5 mode writes
// - Watchdog blocks counter byte writes
// - High byte read returns snapshot
// - Sixteen-bit counter, two bytes, zero reset
// - Low byte write clears comparator enable
// - High byte write sets comparator enable
// - Select bit redirects to reload bytes
// - Configuration bit 7 is reload select
`timescale 1ns/1ps
`include "cca_params.svh"
module cca_core #(
  parameter int NMOD = `CCA_NUM_MODULES
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Register port.
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire cca_pkg::cca_byte_t    reg_wdata,
  output logic      [7:0]            reg_rdata,
  // Counter control.
  input  wire logic                  count_tick,
  input  wire logic                  counter_run,
  input  wire logic                  watchdog_enable,
  // Module pins.
  input  wire logic [NMOD-1:0]       module_io_pin_in,
  output logic      [NMOD-1:0]       module_io_pin,
  // Flags and requests.
  input  wire logic [NMOD-1:0]       module_flag_clear,
  output logic      [NMOD-1:0]       module_event_flag,
  output logic      [NMOD-1:0]       module_irq,
  output logic                       cycle_overflow_irq
);
  import cca_pkg::*;

  cca_word_t            counter;
  cca_byte_t            snapshot;
  cca_byte_t            mode [NMOD];
  cca_word_t            cmp [NMOD];
  cca_word_t            reload [NMOD];
  logic                 reload_access_select;
  logic                 cycle_overflow_irq_enable;
  logic                 cycle_overflow_flag;
  cca_cycle_length_select_t           cycle_length_select;
  logic [NMOD-1:0]      pin_meta;
  logic [NMOD-1:0]      pin_sync;
  logic [NMOD-1:0]      pin_prev;
  logic                 cycle_wrap;
  cca_word_t            next_counter;
  logic [10:0]          cycle_mask;
  logic [NMOD-1:0]      hit;
  logic [NMOD-1:0]      cap_event;
  logic [NMOD-1:0]      sel_low;
  logic [NMOD-1:0]      sel_high;

  // Cycle wraps when the selected low bits roll over to zero.
  always_comb
  begin
    unique case (cycle_length_select)
      2'b00: cycle_mask = 11'h0FF;
      2'b01: cycle_mask = 11'h1FF;
      2'b10: cycle_mask = 11'h3FF;
      2'b11: cycle_mask = 11'h7FF;
    endcase
  end

  assign next_counter = counter + 16'h0001;
  assign cycle_wrap   = count_tick && counter_run &&
                        ((next_counter[10:0] & cycle_mask) == 11'h000);

  function automatic logic [7:0] addr_low(input int i);
    unique case (i)
      0: addr_low = `CCA_ADDR_CMPL0;
      1: addr_low = `CCA_ADDR_CMPL1;
      2: addr_low = `CCA_ADDR_CMPL2;
      3: addr_low = `CCA_ADDR_CMPL3;
      4: addr_low = `CCA_ADDR_CMPL4;
      default: addr_low = `CCA_ADDR_CMPL5;
    endcase
  endfunction

  function automatic logic [7:0] addr_mode(input int i);
    unique case (i)
      0: addr_mode = `CCA_ADDR_MODE0;
      1: addr_mode = `CCA_ADDR_MODE1;
      2: addr_mode = `CCA_ADDR_MODE2;
      3: addr_mode = `CCA_ADDR_MODE3;
      4: addr_mode = `CCA_ADDR_MODE4;
      default: addr_mode = `CCA_ADDR_MODE5;
    endcase
  endfunction

  // High byte addresses sit one above the low byte for every module.
  always_comb
  begin
    for (int i = 0; i < NMOD; i++)
    begin
      sel_low[i]  = (reg_addr == addr_low(i));
      sel_high[i] = (reg_addr == 8'(addr_low(i) + 8'h01));
    end
  end

  // Counter and high byte snapshot.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      counter  <= 16'h0000;
      snapshot <= `CCA_RESET_BYTE;
    end
    else
    begin
      if (reg_rd && reg_addr == `CCA_ADDR_CNTL)
        snapshot <= counter[15:8];
      if (reg_wr && !watchdog_enable && reg_addr == `CCA_ADDR_CNTL)
        counter[7:0] <= reg_wdata;
      else if (reg_wr && !watchdog_enable && reg_addr == `CCA_ADDR_CNTH)
        counter[15:8] <= reg_wdata;
      else if (count_tick && counter_run)
        counter <= next_counter;
    end
  end

  // PWM configuration register.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reload_access_select      <= 1'b0;
      cycle_overflow_irq_enable <= 1'b0;
      cycle_overflow_flag       <= 1'b0;
      cycle_length_select       <= 2'b00;
    end
    else
    begin
      if (reg_wr && reg_addr == `CCA_ADDR_PWMCFG)
      begin
        reload_access_select      <= reg_wdata[`CCA_CFG_RELOAD_ACCESS_SELECT];
        cycle_overflow_irq_enable <= reg_wdata[`CCA_CFG_COVIE];
        cycle_length_select       <= reg_wdata[1:0];
        cycle_overflow_flag       <= reg_wdata[`CCA_CFG_CYCLE_OVERFLOW_FLAG] | cycle_wrap;
      end
      else if (cycle_wrap)
        cycle_overflow_flag <= 1'b1;
    end
  end

  assign cycle_overflow_irq = cycle_overflow_flag && cycle_overflow_irq_enable;

  // Input synchronisers and edge history.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end
    else
    begin
      pin_meta <= module_io_pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Per-module logic.
  for (genvar g = 0; g < NMOD; g++)
  begin : g_mod
    logic      wide;
    logic      pwm_on;
    logic      freq_on;
    logic      mode_wr_ok;
    cca_word_t pwm_cmp;
    cca_word_t pwm_cnt;

    assign wide       = mode[g][`CCA_MODE_WIDE];
    assign pwm_on     = mode[g][`CCA_MODE_PWM] && !mode[g][`CCA_MODE_TOGGLE];
    assign freq_on    = mode[g][`CCA_MODE_PWM] && mode[g][`CCA_MODE_TOGGLE];
    assign mode_wr_ok = !(g == `CCA_WDOG_MODULE && watchdog_enable);
    assign hit[g]     = mode[g][`CCA_MODE_CMP] && count_tick && counter_run &&
                        (freq_on ? (counter[7:0] == cmp[g][7:0])
                                 : (counter == cmp[g]));
    assign cap_event[g] = (mode[g][`CCA_MODE_RISE] && pin_sync[g] && !pin_prev[g]) ||
                          (mode[g][`CCA_MODE_FALL] && !pin_sync[g] && pin_prev[g]);
    // Cycle length only shapes the non-16-bit compare window.
    assign pwm_cmp = wide ? cmp[g] : {5'b00000, cmp[g][10:0] & cycle_mask};
    assign pwm_cnt = wide ? counter : {5'b00000, counter[10:0] & cycle_mask};

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        mode[g]   <= `CCA_RESET_BYTE;
        cmp[g]    <= 16'h0000;
        reload[g] <= 16'h0000;
      end
      else
      begin
        if (reg_wr && reg_addr == addr_mode(g) && mode_wr_ok)
          mode[g] <= reg_wdata;
        else if (reg_wr && sel_low[g] && !reload_access_select)
          mode[g][`CCA_MODE_CMP] <= 1'b0;
        else if (reg_wr && sel_high[g] && !reload_access_select)
          mode[g][`CCA_MODE_CMP] <= 1'b1;
        if (reg_wr && sel_low[g] && reload_access_select)
          reload[g][7:0] <= reg_wdata;
        if (reg_wr && sel_high[g] && reload_access_select)
          reload[g][15:8] <= reg_wdata;
        if (reg_wr && sel_low[g] && !reload_access_select)
          cmp[g][7:0] <= reg_wdata;
        else if (reg_wr && sel_high[g] && !reload_access_select)
          cmp[g][15:8] <= reg_wdata;
        else if (cap_event[g])
          cmp[g] <= counter;
        else if (pwm_on && !wide && cycle_wrap && cycle_length_select != 2'b00)
          cmp[g] <= reload[g];
      end
    end

    // Event flag: a hardware set wins over a clear in the same cycle.
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        module_event_flag[g] <= 1'b0;
      else if ((hit[g] && mode[g][`CCA_MODE_MATCH]) || cap_event[g])
        module_event_flag[g] <= 1'b1;
      else if (module_flag_clear[g])
        module_event_flag[g] <= 1'b0;
    end

    assign module_irq[g] = module_event_flag[g] && mode[g][`CCA_MODE_IRQ];

    // Output pin.
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        module_io_pin[g] <= 1'b0;
      else if (pwm_on)
        module_io_pin[g] <= mode[g][`CCA_MODE_CMP] && (pwm_cnt >= pwm_cmp);
      else if (hit[g] && mode[g][`CCA_MODE_TOGGLE])
        module_io_pin[g] <= !module_io_pin[g];
    end

    a_low_clears_cmp: assert property (@(posedge clk) disable iff (reset)
      reg_wr && sel_low[g] && !reload_access_select && reg_addr != addr_mode(g)
      |=> !mode[g][`CCA_MODE_CMP])
      else $error("low byte write left comparator enabled");
    a_high_sets_cmp: assert property (@(posedge clk) disable iff (reset)
      reg_wr && sel_high[g] && !reload_access_select |=> mode[g][`CCA_MODE_CMP])
      else $error("high byte write did not enable comparator");
    a_match_sets_flag: assert property (@(posedge clk) disable iff (reset)
      hit[g] && mode[g][`CCA_MODE_MATCH] |=> module_event_flag[g])
      else $error("match did not set event flag");
    a_toggle_on_hit: assert property (@(posedge clk) disable iff (reset)
      hit[g] && mode[g][`CCA_MODE_TOGGLE] && !mode[g][`CCA_MODE_PWM]
      |=> module_io_pin[g] != $past(module_io_pin[g]))
      else $error("toggle did not invert pin");
    a_irq_mask: assert property (@(posedge clk) disable iff (reset)
      module_irq[g] |-> module_event_flag[g] && mode[g][`CCA_MODE_IRQ])
      else $error("interrupt request without enabled flag");

    // Capture, flag and frequency output paths.
    a_capture_load: assert property (@(posedge clk) disable iff (reset)
      cap_event[g] && !(reg_wr && (sel_low[g] || sel_high[g]))
      |=> cmp[g] == $past(counter) && module_event_flag[g])
      else $error("capture did not load counter and flag");
    a_flag_clear: assert property (@(posedge clk) disable iff (reset)
      module_flag_clear[g] && !(hit[g] && mode[g][`CCA_MODE_MATCH]) && !cap_event[g]
      |=> !module_event_flag[g])
      else $error("event flag not cleared");
    a_freq_toggle: assert property (@(posedge clk) disable iff (reset)
      freq_on && hit[g] |=> module_io_pin[g] != $past(module_io_pin[g]))
      else $error("frequency output did not toggle");

    // Pulse width paths.
    a_wide_level: assert property (@(posedge clk) disable iff (reset)
      pwm_on && wide
      |=> module_io_pin[g] == $past(mode[g][`CCA_MODE_CMP] && counter >= cmp[g]))
      else $error("wide pulse width level wrong");
    a_reload_copy: assert property (@(posedge clk) disable iff (reset)
      pwm_on && !wide && cycle_wrap && cycle_length_select != 2'b00 &&
      !reg_wr && !cap_event[g]
      |=> cmp[g] == $past(reload[g]))
      else $error("reload value not copied at cycle wrap");

    // A redirected or blocked write must leave the mode byte alone.
    a_reload_write: assert property (@(posedge clk) disable iff (reset)
      reg_wr && sel_low[g] && reload_access_select
      |=> reload[g][7:0] == $past(reg_wdata) && $stable(mode[g]))
      else $error("reload low byte write misrouted");
    a_mode5_locked: assert property (@(posedge clk) disable iff (reset)
      g == `CCA_WDOG_MODULE && watchdog_enable && reg_wr && reg_addr == addr_mode(g)
      |=> $stable(mode[g]))
      else $error("watchdog module mode changed by write");
    c_freq_toggle: cover property (@(posedge clk) disable iff (reset) freq_on && hit[g]);
    c_reload_copy: cover property (@(posedge clk) disable iff (reset)
      pwm_on && !wide && cycle_wrap && cycle_length_select != 2'b00);
  end

  // Read multiplexer.
  always_comb
  begin
    reg_rdata = 8'h00;
    if (reg_addr == `CCA_ADDR_CNTL)
      reg_rdata = counter[7:0];
    else if (reg_addr == `CCA_ADDR_CNTH)
      reg_rdata = snapshot;
    else if (reg_addr == `CCA_ADDR_PWMCFG)
      reg_rdata = {reload_access_select, cycle_overflow_irq_enable,
                   cycle_overflow_flag, 3'b000, cycle_length_select};
    for (int i = 0; i < NMOD; i++)
    begin
      if (reg_addr == addr_mode(i))
        reg_rdata = mode[i];
      if (sel_low[i])
        reg_rdata = reload_access_select ? reload[i][7:0] : cmp[i][7:0];
      if (sel_high[i])
        reg_rdata = reload_access_select ? reload[i][15:8] : cmp[i][15:8];
    end
  end

  a_wrap_sets_cov: assert property (@(posedge clk) disable iff (reset)
    cycle_wrap |=> cycle_overflow_flag)
    else $error("cycle overflow missed");
  a_cov_sticky: assert property (@(posedge clk) disable iff (reset)
    cycle_overflow_flag && !(reg_wr && reg_addr == `CCA_ADDR_PWMCFG) |=> cycle_overflow_flag)
    else $error("cycle flag cleared by hardware");
  a_wdog_counter: assert property (@(posedge clk) disable iff (reset)
    watchdog_enable && !(count_tick && counter_run) |=> counter == $past(counter))
    else $error("counter changed under watchdog");
  a_snap_hold: assert property (@(posedge clk) disable iff (reset)
    !(reg_rd && reg_addr == `CCA_ADDR_CNTL) |=> $stable(snapshot))
    else $error("snapshot changed without low byte read");
  a_cfg_zero: assert property (@(posedge clk) disable iff (reset)
    reg_addr == `CCA_ADDR_PWMCFG |-> reg_rdata[4:2] == 3'b000)
    else $error("unused configuration bits not zero");
  a_snap_load: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `CCA_ADDR_CNTL |=> snapshot == $past(counter[15:8]))
    else $error("snapshot not loaded from counter high byte");
  a_count_step: assert property (@(posedge clk) disable iff (reset)
    count_tick && counter_run &&
    !(reg_wr && (reg_addr == `CCA_ADDR_CNTL || reg_addr == `CCA_ADDR_CNTH))
    |=> counter == $past(counter) + 16'h0001)
    else $error("counter did not advance on tick");
  a_cfg_load: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == `CCA_ADDR_PWMCFG
    |=> reload_access_select == $past(reg_wdata[`CCA_CFG_RELOAD_ACCESS_SELECT]) &&
        cycle_length_select == $past(reg_wdata[1:0]))
    else $error("configuration write not taken");
  c_overflow: cover property (@(posedge clk) disable iff (reset) cycle_wrap);
  c_snapshot: cover property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == `CCA_ADDR_CNTL ##1 reg_rd && reg_addr == `CCA_ADDR_CNTH);
  c_flag: cover property (@(posedge clk) disable iff (reset) |module_event_flag);
endmodule

// [dv/cca_pin_model.sv]
// Far-side pin model: drives the capture inputs and counts output pin changes.
`timescale 1ns/1ps
module cca_pin_model (
  // Clock.
  input  wire logic       clk,
  // Module pins.
  input  wire logic [5:0] module_io_pin,
  output logic      [5:0] module_io_pin_in
);
  int unsigned n_toggle [6];
  logic [5:0]  last_pin = 6'h00;
  initial module_io_pin_in = 6'h00;
  // An edge is held for several clocks so the two-flop synchroniser sees it.
  task automatic drive(input int idx, input logic lvl);
    @(posedge clk);
    #1;
    module_io_pin_in[idx] = lvl;
    repeat (5) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    for (int i = 0; i < 6; i++)
      if (module_io_pin[i] !== last_pin[i])
        n_toggle[i]++;
    last_pin <= module_io_pin;
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the counter array registers, counter and module pins.
`timescale 1ns/1ps
`include "cca_params.svh"
module testbench;
  import cca_pkg::*;
  localparam logic [7:0] CFG = `CCA_ADDR_PWMCFG;
  localparam logic [7:0] CL = `CCA_ADDR_CNTL;
  localparam logic [7:0] CH = `CCA_ADDR_CNTH;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  cca_byte_t   reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        count_tick = 1'b0;
  logic        counter_run = 1'b0;
  logic        wd_en = 1'b0;
  logic [5:0]  pin_in;
  logic [5:0]  pin_out;
  logic [5:0]  flag_clr = 6'h00;
  logic [5:0]  ev_flag;
  logic [5:0]  mod_irq;
  logic        cov_irq;
  int          n_mismatch = 0;
  int          n_checks = 0;
  cca_byte_t   m;
  cca_byte_t   v;
  logic        p;
  int unsigned t0;
  logic [7:0]  cl [5] = '{`CCA_ADDR_CMPL0, `CCA_ADDR_CMPL1, `CCA_ADDR_CMPL2,
                          `CCA_ADDR_CMPL3, `CCA_ADDR_CMPL4};
  always #4 clk = ~clk;
  cca_core uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .count_tick(count_tick), .counter_run(counter_run), .watchdog_enable(wd_en),
    .module_io_pin_in(pin_in), .module_io_pin(pin_out), .module_flag_clear(flag_clr),
    .module_event_flag(ev_flag), .module_irq(mod_irq), .cycle_overflow_irq(cov_irq));
  cca_pin_model pins (.clk(clk), .module_io_pin(pin_out), .module_io_pin_in(pin_in));
  function automatic logic [7:0] mode_addr(input int i);
    return (i == 5) ? `CCA_ADDR_MODE5 : 8'(`CCA_ADDR_MODE0 + i);
  endfunction
  function automatic cca_word_t wrap_val(input int code);
    return cca_word_t'((1 << (8 + code)) - 1);
  endfunction
  function automatic cca_byte_t bit8(input logic x);
    return {7'h00, x};
  endfunction
  task automatic chk(input cca_byte_t got, input cca_byte_t exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input cca_byte_t d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input cca_byte_t exp);
    cca_byte_t d;
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    d = reg_rdata;
    #1;
    reg_rd = 1'b0;
    chk(d, exp);
  endtask
  task automatic wr16(input logic [7:0] lo, input cca_word_t w);
    wr(lo, w[7:0]);
    wr(lo + 8'h01, w[15:8]);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      count_tick = 1'b1;
      @(posedge clk);
      #1;
      count_tick = 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic clr_flags;
    @(posedge clk);
    #1;
    flag_clr = 6'h3f;
    @(posedge clk);
    #1;
    flag_clr = 6'h00;
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(75));
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 6; i++)
      rchk(mode_addr(i), 8'h00);
    rchk(CL, 8'h00);
    rchk(CH, 8'h00);
    wr(CFG, 8'hff);
    rchk(CFG, 8'hff & `CCA_CFG_WMASK);
    wr(CFG, 8'h00);
    rchk(CFG, 8'h00);
    // Random modes, then the comparator enable side effects of compare writes.
    for (int i = 0; i < 5; i++)
    begin
      m = 8'($urandom);
      v = 8'($urandom);
      wr(mode_addr(i), m);
      rchk(mode_addr(i), m);
      wr(cl[i], v);
      rchk(mode_addr(i), m & 8'hbf);
      wr(cl[i] + 8'h01, m);
      rchk(mode_addr(i), m | 8'h40);
      rchk(cl[i], v);
    end
    wr16(cl[0], 16'h5aa5);
    wr(CFG, 8'h80);
    wr16(cl[0], 16'h3cc3);
    rchk(cl[0], 8'hc3);
    wr(CFG, 8'h00);
    rchk(cl[0], 8'ha5);
    // Snapshot of the high byte is taken only on a low byte read.
    wr16(CL, 16'h12ab);
    rchk(CL, 8'hab);
    rchk(CH, 8'h12);
    wr(CH, 8'h34);
    rchk(CH, 8'h12);
    rchk(CL, 8'hab);
    rchk(CH, 8'h34);
    wd_en = 1'b1;
    counter_run = 1'b1;
    wr(mode_addr(5), 8'hff);
    wr16(CL, 16'h0000);
    rchk(mode_addr(5), 8'h00);
    rchk(CL, 8'hab);
    rchk(CH, 8'h34);
    wd_en = 1'b0;
    wr(mode_addr(5), 8'h01);
    rchk(mode_addr(5), 8'h01);
    // Each cycle length code: a low byte wrap flags only in 8-bit mode.
    for (int c = 0; c < 4; c++)
    begin
      wr(CFG, 8'(c));
      wr16(CL, 16'h00ff);
      tick(1);
      rchk(CFG, 8'(c) | ((c == 0) ? 8'h20 : 8'h00));
      wr(CFG, 8'(c));
      wr16(CL, wrap_val(c) - 16'h0001);
      tick(1);
      rchk(CFG, 8'(c));
      tick(1);
      rchk(CFG, 8'h20 | 8'(c));
      wr(CFG, 8'h60 | 8'(c));
      chk(bit8(cov_irq), 8'h01);
    end
    wr(CFG, 8'h00);
    chk(bit8(cov_irq), 8'h00);
    // Match and toggle on module 1 with its flag request unmasked.
    wr16(CL, 16'h0003);
    wr16(cl[1], 16'h0005);
    wr(mode_addr(1), 8'h4d);
    clr_flags();
    p = pin_out[1];
    t0 = pins.n_toggle[1];
    tick(3);
    chk(bit8(ev_flag[1]), 8'h01);
    chk(bit8(pin_out[1]), bit8(~p));
    chk(8'(pins.n_toggle[1] - t0), 8'h01);
    chk(bit8(mod_irq[1]), 8'h01);
    wr(mode_addr(1), 8'h4c);
    chk(bit8(mod_irq[1]), 8'h00);
    // Edge capture on module 2 with the counter stopped at 6.
    counter_run = 1'b0;
    wr(mode_addr(2), 8'h20);
    clr_flags();
    pins.drive(2, 1'b1);
    chk(bit8(ev_flag[2]), 8'h01);
    rchk(cl[2], 8'h06);
    clr_flags();
    pins.drive(2, 1'b0);
    chk(bit8(ev_flag[2]), 8'h00);
    wr(mode_addr(2), 8'h10);
    pins.drive(2, 1'b1);
    chk(bit8(ev_flag[2]), 8'h00);
    pins.drive(2, 1'b0);
    chk(bit8(ev_flag[2]), 8'h01);
    // Module 3 PWM: 8-bit width ignores the compare high byte, 16-bit does not.
    wr16(cl[3], 16'h8000);
    wr16(CL, 16'h00ff);
    wr(mode_addr(3), 8'h42);
    tick(0);
    chk(bit8(pin_out[3]), 8'h01);
    wr(mode_addr(3), 8'hc2);
    tick(0);
    chk(bit8(pin_out[3]), 8'h00);
    // Module 4 in 9-bit PWM picks up its reload value at the cycle wrap.
    wr(CFG, 8'h81);
    wr16(cl[4], 16'h1234);
    wr(CFG, 8'h01);
    wr16(cl[4], 16'h0000);
    wr(mode_addr(4), 8'h42);
    counter_run = 1'b1;
    wr16(CL, 16'h01ff);
    tick(1);
    rchk(cl[4], 8'h34);
    rchk(cl[4] + 8'h01, 8'h12);
    // Module 0 in frequency output toggles on a low byte match alone.
    wr16(cl[0], 16'h5501);
    wr(mode_addr(0), 8'h46);
    p = pin_out[0];
    tick(2);
    chk(bit8(pin_out[0]), bit8(~p));
    print_verdict();
  end
endmodule
